// ### src/acs_adc_conversion_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.vh"

module acs_adc_conversion_sequencer #(
  parameter DATA_W = 10
) (
  // Clock and reset
  input  wire              ref_clk,
  input  wire              reset,
  // Register port
  input  wire [7:0]        regAddr,
  input  wire [7:0]        regWrData,
  input  wire              regWrite,
  input  wire              regRead,
  output reg  [7:0]        regRdData,
  // Chip sleep state
  input  wire              sleepStandby,
  input  wire              sleepDeep,
  // Analog core
  input  wire [DATA_W-1:0] coreData,
  output reg               coreEnable,
  output reg               coreSample,
  output reg               coreConvert,
  output reg               converterClockPulse,
  output reg               sampleCapacitanceSelect,
  output reg               voltageReferenceSelect,
  // Status
  output reg               conversionBusy
);

  localparam [5:0] ST_IDLE  = 6'b00_0001;
  localparam [5:0] ST_INIT  = 6'b00_0010;
  localparam [5:0] ST_SAMP  = 6'b00_0100;
  localparam [5:0] ST_CONV  = 6'b00_1000;
  localparam [5:0] ST_DELAY = 6'b01_0000;
  localparam [5:0] ST_DONE  = 6'b10_0000;

  reg  [7:0]  mainCtrl_q;
  reg  [2:0]  accumulationCount_q;
  reg  [7:0]  refClkCtrl_q;
  reg  [2:0]  startupDelay_q;
  reg         delayVariationEnable_q;
  reg  [3:0]  interSampleDelay_q;
  reg  [2:0]  windowMode_q;
  reg  [4:0]  samplePhaseExtension_q;
  reg  [15:0] windowLowThreshold_q;
  reg  [15:0] windowHighThreshold_q;
  reg  [15:0] conversionOutput_q;
  reg  [15:0] accum_q;
  reg         resultReadyFlag_q;
  reg         windowMatchFlag_q;
  reg         startConversionCommand_q;
  reg  [5:0]  state_q;
  reg  [8:0]  phaseCnt_q;
  reg  [6:0]  sampleCnt_q;
  reg  [7:0]  divCnt_q;
  reg         needInit_q;
  reg         deepPrev_q;
  reg         refPrev_q;

  wire keepRunningInStandby = mainCtrl_q[`ACS_BIT_STANDBY];
  wire resolutionSelect     = mainCtrl_q[`ACS_BIT_RESOLUTION_SELECT];
  wire continuousConversion = mainCtrl_q[`ACS_BIT_CONTINUOUS_CONVERSION];
  wire enableBit            = mainCtrl_q[`ACS_BIT_ENABLE];
  wire [1:0] refField       = refClkCtrl_q[5:4];
  wire [2:0] clockDividerSelect = refClkCtrl_q[2:0];

  // Converter halts in standby unless told to keep running
  wire active = enableBit && !sleepDeep &&
                (!sleepStandby || keepRunningInStandby);

  wire wrMain  = regWrite && (regAddr == `ACS_OFF_MAIN);
  wire wrCmd   = regWrite && (regAddr == `ACS_OFF_COMMAND);
  wire wrFlags = regWrite && (regAddr == `ACS_OFF_FLAGS);
  wire rdRes   = regRead && ((regAddr == `ACS_OFF_RESLO) || (regAddr == `ACS_OFF_RESHI));
  wire startReq = wrCmd && regWrData[0];
  wire abortReq = wrCmd && !regWrData[0];

  // Converter clock enable from the prescaler
  wire [7:0] divMask = (8'h02 << clockDividerSelect) - 8'h01;
  wire       tick    = ((divCnt_q & divMask) == divMask);

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      divCnt_q            <= 8'h00;
      converterClockPulse <= 1'b0;
    end else begin
      divCnt_q            <= active ? divCnt_q + 8'h01 : 8'h00;
      converterClockPulse <= active && tick;
    end
  end

  // Reserved codes fold onto code zero
  wire [6:0] samplesTarget = (accumulationCount_q == 3'h7) ? 7'h01 :
                             (7'h01 << accumulationCount_q);
  wire       useInternalRef = (refField == 2'h0) || (refField[1]);
  reg  [8:0] initCycles;
  always @* begin
    case (startupDelay_q)
      3'h1:    initCycles = 9'h010;
      3'h2:    initCycles = 9'h020;
      3'h3:    initCycles = 9'h040;
      3'h4:    initCycles = 9'h080;
      3'h5:    initCycles = 9'h100;
      default: initCycles = 9'h000;
    endcase
  end

  wire [5:0]  sampleCycles = `ACS_SAMPLE_BASE + {1'b0, samplePhaseExtension_q};
  wire [15:0] sampleValue  = resolutionSelect ?
                             {8'h00, coreData[DATA_W-1:DATA_W-8]} :
                             {{(16-DATA_W){1'b0}}, coreData};
  wire [15:0] accumNext    = accum_q + sampleValue;

  reg winMatch;
  always @* begin
    case (windowMode_q)
      3'h1:    winMatch = accumNext < windowLowThreshold_q;
      3'h2:    winMatch = accumNext > windowHighThreshold_q;
      3'h3:    winMatch = (accumNext > windowLowThreshold_q) &&
                          (accumNext < windowHighThreshold_q);
      3'h4:    winMatch = (accumNext < windowLowThreshold_q) ||
                          (accumNext > windowHighThreshold_q);
      default: winMatch = 1'b0;
    endcase
  end

  wire phaseEnd   = tick && (phaseCnt_q == 9'h000);
  wire lastSample = (sampleCnt_q + 7'h01 == samplesTarget);
  wire finish     = (state_q == ST_CONV) && phaseEnd && lastSample;

  // Sequencer
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q                  <= ST_IDLE;
      phaseCnt_q               <= 9'h000;
      sampleCnt_q              <= 7'h00;
      accum_q                  <= 16'h0000;
      conversionOutput_q       <= 16'h0000;
      startConversionCommand_q <= 1'b0;
      needInit_q               <= 1'b1;
      deepPrev_q               <= 1'b0;
      refPrev_q                <= 1'b0;
    end else begin
      deepPrev_q <= sleepDeep;
      refPrev_q  <= useInternalRef;
      // Fresh enable, deep-sleep wake or switch to internal ref re-arms the delay
      if (!enableBit || (deepPrev_q && !sleepDeep) || (useInternalRef && !refPrev_q)) begin
        needInit_q <= 1'b1;
      end
      if (!enableBit || abortReq) begin
        state_q                  <= ST_IDLE;
        startConversionCommand_q <= 1'b0;
      end else if (active) begin
        case (state_q)
          ST_IDLE: begin
            if (startReq) begin
              startConversionCommand_q <= 1'b1;
              sampleCnt_q <= 7'h00;
              accum_q     <= 16'h0000;
              if (needInit_q && (initCycles != 9'h000)) begin
                state_q    <= ST_INIT;
                phaseCnt_q <= initCycles - 9'h001;
              end else begin
                state_q    <= ST_SAMP;
                phaseCnt_q <= {3'h0, sampleCycles} - 9'h001;
              end
              needInit_q <= 1'b0;
            end
          end
          ST_INIT: begin
            if (phaseEnd) begin
              state_q    <= ST_SAMP;
              phaseCnt_q <= {3'h0, sampleCycles} - 9'h001;
            end else if (tick) begin
              phaseCnt_q <= phaseCnt_q - 9'h001;
            end
          end
          ST_SAMP: begin
            if (phaseEnd) begin
              state_q    <= ST_CONV;
              phaseCnt_q <= {3'h0, `ACS_CONV_CYCLES} - 9'h001;
            end else if (tick) begin
              phaseCnt_q <= phaseCnt_q - 9'h001;
            end
          end
          ST_CONV: begin
            if (phaseEnd) begin
              accum_q     <= accumNext;
              sampleCnt_q <= sampleCnt_q + 7'h01;
              if (lastSample) begin
                conversionOutput_q <= accumNext;
                state_q            <= ST_DONE;
              end else if (interSampleDelay_q != 4'h0) begin
                state_q    <= ST_DELAY;
                phaseCnt_q <= {5'h00, interSampleDelay_q} - 9'h001;
              end else begin
                state_q    <= ST_SAMP;
                phaseCnt_q <= {3'h0, sampleCycles} - 9'h001;
              end
            end else if (tick) begin
              phaseCnt_q <= phaseCnt_q - 9'h001;
            end
          end
          ST_DELAY: begin
            if (phaseEnd) begin
              state_q    <= ST_SAMP;
              phaseCnt_q <= {3'h0, sampleCycles} - 9'h001;
            end else if (tick) begin
              phaseCnt_q <= phaseCnt_q - 9'h001;
            end
          end
          ST_DONE: begin
            sampleCnt_q <= 7'h00;
            accum_q     <= 16'h0000;
            if (continuousConversion) begin
              state_q    <= ST_SAMP;
              phaseCnt_q <= {3'h0, sampleCycles} - 9'h001;
            end else begin
              state_q                  <= ST_IDLE;
              startConversionCommand_q <= 1'b0;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Registers and flags
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mainCtrl_q             <= `ACS_RST_REG;
      accumulationCount_q    <= 3'h0;
      refClkCtrl_q           <= `ACS_RST_REG;
      startupDelay_q         <= 3'h0;
      delayVariationEnable_q <= 1'b0;
      interSampleDelay_q     <= 4'h0;
      windowMode_q           <= 3'h0;
      samplePhaseExtension_q <= 5'h00;
      windowLowThreshold_q   <= 16'h0000;
      windowHighThreshold_q  <= 16'h0000;
      resultReadyFlag_q      <= 1'b0;
      windowMatchFlag_q      <= 1'b0;
    end else begin
      if (wrMain) mainCtrl_q <= regWrData;
      if (regWrite && regAddr == `ACS_OFF_ACCUM) accumulationCount_q <= regWrData[2:0];
      if (regWrite && regAddr == `ACS_OFF_REFCLK) refClkCtrl_q <= {1'b0, regWrData[6:4],
                                                                  1'b0, regWrData[2:0]};
      if (regWrite && regAddr == `ACS_OFF_WINDOW) windowMode_q <= regWrData[2:0];
      if (regWrite && regAddr == `ACS_OFF_SAMPLE_PHASE_EXTENSION) samplePhaseExtension_q <= regWrData[4:0];
      if (regWrite && regAddr == `ACS_OFF_WINLO_L) windowLowThreshold_q[7:0] <= regWrData;
      if (regWrite && regAddr == `ACS_OFF_WINLO_H) windowLowThreshold_q[15:8] <= regWrData;
      if (regWrite && regAddr == `ACS_OFF_WINHI_L) windowHighThreshold_q[7:0] <= regWrData;
      if (regWrite && regAddr == `ACS_OFF_WINHI_H) windowHighThreshold_q[15:8] <= regWrData;
      if (regWrite && regAddr == `ACS_OFF_DELAY) begin
        startupDelay_q         <= regWrData[7:5];
        delayVariationEnable_q <= regWrData[`ACS_BIT_VARY];
        interSampleDelay_q     <= regWrData[3:0];
      end else if (active && delayVariationEnable_q && (state_q == ST_CONV) && phaseEnd) begin
        interSampleDelay_q <= interSampleDelay_q + 4'h1;
      end
      // Set wins over a same-cycle clear
      if (finish) begin
        resultReadyFlag_q <= 1'b1;
      end else if (rdRes || (wrFlags && regWrData[`ACS_BIT_FLAG_RDY])) begin
        resultReadyFlag_q <= 1'b0;
      end
      if (finish && winMatch) begin
        windowMatchFlag_q <= 1'b1;
      end else if (rdRes || (wrFlags && regWrData[`ACS_BIT_FLAG_WIN])) begin
        windowMatchFlag_q <= 1'b0;
      end
    end
  end

  // Outputs to the analog core, plus the busy status
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      coreEnable              <= 1'b0;
      coreSample              <= 1'b0;
      coreConvert             <= 1'b0;
      sampleCapacitanceSelect <= 1'b0;
      voltageReferenceSelect  <= 1'b0;
      conversionBusy          <= 1'b0;
    end else begin
      coreEnable              <= active;
      // Capacitor closed only in the sampling phase, open during delays
      coreSample              <= active && (state_q == ST_SAMP);
      coreConvert             <= active && (state_q == ST_CONV);
      sampleCapacitanceSelect <= refClkCtrl_q[`ACS_BIT_SAMPLE_CAPACITANCE_SELECT];
      voltageReferenceSelect  <= !useInternalRef;
      conversionBusy          <= startConversionCommand_q;
    end
  end

  // Read port, data one cycle after the strobe
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `ACS_OFF_MAIN:    regRdData <= {mainCtrl_q[7], 4'h0, mainCtrl_q[2:0]};
        `ACS_OFF_ACCUM:   regRdData <= {5'h00, accumulationCount_q};
        `ACS_OFF_REFCLK:  regRdData <= refClkCtrl_q;
        `ACS_OFF_DELAY:   regRdData <= {startupDelay_q, delayVariationEnable_q,
                                        interSampleDelay_q};
        `ACS_OFF_WINDOW:  regRdData <= {5'h00, windowMode_q};
        `ACS_OFF_SAMPLE_PHASE_EXTENSION: regRdData <= {3'h0, samplePhaseExtension_q};
        `ACS_OFF_COMMAND: regRdData <= {7'h00, startConversionCommand_q};
        `ACS_OFF_FLAGS:   regRdData <= {6'h00, windowMatchFlag_q, resultReadyFlag_q};
        `ACS_OFF_RESLO:   regRdData <= conversionOutput_q[7:0];
        `ACS_OFF_RESHI:   regRdData <= conversionOutput_q[15:8];
        `ACS_OFF_WINLO_L: regRdData <= windowLowThreshold_q[7:0];
        `ACS_OFF_WINLO_H: regRdData <= windowLowThreshold_q[15:8];
        `ACS_OFF_WINHI_L: regRdData <= windowHighThreshold_q[7:0];
        `ACS_OFF_WINHI_H: regRdData <= windowHighThreshold_q[15:8];
        `ACS_OFF_SLEEP:   regRdData <= {6'h00, sleepDeep, sleepStandby};
        default:          regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ### shared/acs_consts.vh
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// Register offsets
`define ACS_OFF_MAIN      8'h00
`define ACS_OFF_ACCUM     8'h01
`define ACS_OFF_REFCLK    8'h02
`define ACS_OFF_DELAY     8'h03
`define ACS_OFF_WINDOW    8'h04
`define ACS_OFF_SAMPLE_PHASE_EXTENSION   8'h05
`define ACS_OFF_COMMAND   8'h08
`define ACS_OFF_FLAGS     8'h0B
`define ACS_OFF_RESLO     8'h10
`define ACS_OFF_RESHI     8'h11
`define ACS_OFF_WINLO_L   8'h12
`define ACS_OFF_WINLO_H   8'h13
`define ACS_OFF_WINHI_L   8'h14
`define ACS_OFF_WINHI_H   8'h15
`define ACS_OFF_SLEEP     8'h18

// Reset value of every register
`define ACS_RST_REG       8'h00

// Field positions
`define ACS_BIT_ENABLE    0
`define ACS_BIT_CONTINUOUS_CONVERSION   1
`define ACS_BIT_RESOLUTION_SELECT    2
`define ACS_BIT_STANDBY   7
`define ACS_BIT_SAMPLE_CAPACITANCE_SELECT   6
`define ACS_BIT_VARY      4
`define ACS_BIT_FLAG_RDY  0
`define ACS_BIT_FLAG_WIN  1
`define ACS_BIT_SLP_STBY  0
`define ACS_BIT_SLP_DEEP  1

// Timing counts in converter clocks
`define ACS_SAMPLE_BASE   6'h02
`define ACS_CONV_CYCLES   6'h0B

`endif

// ### bench/acs_adc_conversion_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module acs_seq_checker (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  // Sleep and core side
  input wire logic       sleepDeep,
  input wire logic       coreEnable,
  input wire logic       coreSample,
  input wire logic       coreConvert,
  input wire logic       converterClockPulse,
  input wire logic       sampleCapacitanceSelect,
  input wire logic       voltageReferenceSelect,
  input wire logic       conversionBusy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_sample_enabled: assert property (coreSample |-> coreEnable)
    else $error("sampling while converter disabled");
  a_convert_enabled: assert property (coreConvert |-> coreEnable)
    else $error("converting while converter disabled");
  a_phases_apart: assert property (!(coreSample && coreConvert))
    else $error("sample cap closed during convert phase");
  a_pulse_single: assert property (converterClockPulse |=> !converterClockPulse)
    else $error("converter clock pulse longer than one cycle");
  // Two converter clocks span at least three ref clocks; an abort may cut it short
  a_sample_length: assert property ($rose(coreSample) |-> coreSample[*3] or ##[1:5] !conversionBusy)
    else $error("sampling phase too short");
  a_convert_busy: assert property (coreConvert |-> conversionBusy)
    else $error("convert phase without busy");
  a_deep_halt: assert property (sleepDeep |=> !coreEnable)
    else $error("converter enabled in deep sleep");
  a_cap_follow: assert property (regWrite && regAddr == 8'h02
    |-> ##2 sampleCapacitanceSelect == $past(regWrData[6], 2))
    else $error("capacitance select does not follow register");
  a_ref_follow: assert property (regWrite && regAddr == 8'h02
    |-> ##2 voltageReferenceSelect == ($past(regWrData[5:4], 2) == 2'b01))
    else $error("reference select does not follow register");
endmodule

bind acs_adc_conversion_sequencer acs_seq_checker i_acs_seq_checker (
  .ref_clk, .reset, .regAddr, .regWrData, .regWrite, .sleepDeep, .coreEnable, .coreSample,
  .coreConvert, .converterClockPulse, .sampleCapacitanceSelect, .voltageReferenceSelect,
  .conversionBusy
);
`default_nettype wire

// ### bench/acs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
  // Clock
  input  wire logic       ref_clk,
  // Converter control
  input  wire logic       coreEnable,
  input  wire logic       coreSample,
  input  wire logic       coreConvert,
  // Analog input and result
  input  wire logic [9:0] analogLevel,
  output logic      [9:0] coreData
);
  logic [9:0] heldLevel_q = 10'h000;
  // Cap tracks the input only while closed
  always @(posedge ref_clk) begin
    if (coreEnable && coreSample) begin
      heldLevel_q <= analogLevel;
    end
  end
  // Outside the convert phase the bus carries junk, never the last code
  assign coreData = coreConvert ? heldLevel_q : ~heldLevel_q;
endmodule
`default_nettype wire

// ### bench/acs_adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.vh"
module acs_adc_conversion_sequencer_tb;
  logic       ref_clk, reset, regWrite, regRead, sleepStandby, sleepDeep;
  logic [7:0] regAddr, regWrData, rdVal;
  logic [9:0] analogLevel;
  wire  [7:0] regRdData;
  wire  [9:0] coreData;
  wire        coreEnable, coreSample, coreConvert, converterClockPulse;
  wire        sampleCapacitanceSelect, voltageReferenceSelect, conversionBusy;
  integer     fail_count, check_count, a, b;

  acs_adc_conversion_sequencer #(.DATA_W(10)) i_acs_adc_conversion_sequencer (
    .ref_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .sleepStandby,
    .sleepDeep, .coreData, .coreEnable, .coreSample, .coreConvert, .converterClockPulse,
    .sampleCapacitanceSelect, .voltageReferenceSelect, .conversionBusy);
  acs_core_model i_acs_core_model (
    .ref_clk, .coreEnable, .coreSample, .coreConvert, .analogLevel, .coreData);

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= ad;
    regWrData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= ad;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 rdVal = regRdData;
  endtask
  task automatic wait_ready();
    integer n;
    n = 0;
    rdVal = 8'h00;
    while (rdVal[0] !== 1'b1) begin
      if (n++ > 5000) begin
        fail_count++;
        wrap_up();
      end
      rd(`ACS_OFF_FLAGS);
    end
  endtask
  task automatic convert(input logic [9:0] lvl, input logic [15:0] exp, input logic win);
    analogLevel <= lvl;
    wr(`ACS_OFF_COMMAND, 8'h01);
    wait_ready();
    compare(rdVal[1], win);
    rd(`ACS_OFF_RESLO);
    compare(rdVal, exp[7:0]);
    rd(`ACS_OFF_RESHI);
    compare(rdVal, exp[15:8]);
    rd(`ACS_OFF_FLAGS);
    compare(rdVal, 8'h00);
    rd(`ACS_OFF_COMMAND);
    compare(rdVal, 8'h00);
  endtask
  // Busy width from start request; fixed offsets cancel in differences
  task automatic time_conv(output integer c);
    wr(`ACS_OFF_COMMAND, 8'h01);
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
    end while ((conversionBusy !== 1'b0 || c < 3) && c < 5000);
    if (c >= 5000) begin
      fail_count++;
      wrap_up();
    end
    wr(`ACS_OFF_FLAGS, 8'h03);
  endtask

  task automatic t_regs();
    logic [7:0] mask [6] = '{8'h87, 8'h07, 8'h77, 8'hFF, 8'h07, 8'h1F};
    for (int i = 0; i < 6; i++) begin
      rd(i[7:0]);
      compare(rdVal, 8'h00);
      wr(i[7:0], 8'hFF);
      rd(i[7:0]);
      compare(rdVal, mask[i]);
      wr(i[7:0], 8'h00);
    end
    wr(8'h07, 8'hFF);
    rd(8'h07);
    compare(rdVal, 8'h00);
    wr(`ACS_OFF_REFCLK, 8'h50);
  endtask
  logic [15:0] mask5 [5] = '{16'h0080, 16'h0100, 16'h0150, 16'h0200, 16'h0300};
  task automatic t_convert();
    logic [15:0] r;
    logic        e;
    wr(`ACS_OFF_MAIN, 8'h01);
    convert(10'h2A5, 16'h02A5, 1'b0);
    wr(`ACS_OFF_MAIN, 8'h05);
    convert(10'h2A5, 16'h00A9, 1'b0);
    wr(`ACS_OFF_MAIN, 8'h01);
    for (int k = 0; k < 8; k++) begin
      wr(`ACS_OFF_ACCUM, k[7:0]);
      convert(10'h3FF, 16'h03FF << ((k == 7) ? 0 : k), 1'b0);
    end
    wr(`ACS_OFF_ACCUM, 8'h00);
    wr(`ACS_OFF_WINLO_H, 8'h01);
    wr(`ACS_OFF_WINHI_H, 8'h02);
    for (int m = 0; m < 8; m++) begin
      wr(`ACS_OFF_WINDOW, m[7:0]);
      foreach (mask5[v]) begin
        r = mask5[v];
        case (m)
          1: e = r < 16'h0100;
          2: e = r > 16'h0200;
          3: e = r > 16'h0100 && r < 16'h0200;
          4: e = r < 16'h0100 || r > 16'h0200;
          default: e = 1'b0;
        endcase
        convert(r[9:0], r, e);
      end
    end
    wr(`ACS_OFF_WINDOW, 8'h00);
  endtask
  task automatic t_modes();
    wr(`ACS_OFF_MAIN, 8'h03);
    repeat (100) @(posedge ref_clk);
    rd(`ACS_OFF_FLAGS);
    compare(rdVal, 8'h00);
    wr(`ACS_OFF_COMMAND, 8'h01);
    wait_ready();
    wr(`ACS_OFF_FLAGS, 8'h01);
    wait_ready();
    rd(`ACS_OFF_COMMAND);
    compare(rdVal[0], 1'b1);
    wr(`ACS_OFF_COMMAND, 8'h00);
    wr(`ACS_OFF_FLAGS, 8'h03);
    repeat (200) @(posedge ref_clk);
    rd(`ACS_OFF_FLAGS);
    compare(rdVal, 8'h00);
    wr(`ACS_OFF_MAIN, 8'h00);
    wr(`ACS_OFF_COMMAND, 8'h01);
    repeat (200) @(posedge ref_clk);
    rd(`ACS_OFF_FLAGS);
    compare({rdVal, 7'h00, coreEnable}, 16'h0000);
    wr(`ACS_OFF_MAIN, 8'h01);
    sleepStandby <= 1'b1;
    repeat (4) @(posedge ref_clk);
    compare(coreEnable, 1'b0);
    wr(`ACS_OFF_MAIN, 8'h81);
    repeat (4) @(posedge ref_clk);
    compare(coreEnable, 1'b1);
    sleepStandby <= 1'b0;
    sleepDeep <= 1'b1;
    repeat (4) @(posedge ref_clk);
    compare(coreEnable, 1'b0);
    sleepDeep <= 1'b0;
    wr(`ACS_OFF_MAIN, 8'h01);
  endtask
  task automatic t_timing();
    for (int p = 0; p < 8; p++) begin
      wr(`ACS_OFF_REFCLK, 8'h10 | p[7:0]);
      // Skip a pulse that the old divider may still have launched
      repeat (2) begin
        a = 0;
        @(negedge ref_clk);
        while (converterClockPulse !== 1'b1 && a++ < 600) @(negedge ref_clk);
      end
      b = 0;
      do begin
        @(negedge ref_clk);
        b++;
      end while (converterClockPulse !== 1'b1 && b < 600);
      compare(b, 2 << p);
    end
    wr(`ACS_OFF_REFCLK, 8'h00);
    wr(`ACS_OFF_MAIN, 8'h00);
    wr(`ACS_OFF_MAIN, 8'h01);
    time_conv(a);
    wr(`ACS_OFF_DELAY, 8'h20);
    wr(`ACS_OFF_MAIN, 8'h00);
    wr(`ACS_OFF_MAIN, 8'h01);
    time_conv(b);
    compare(b - a >= 31 && b - a <= 33, 1'b1);
    // Deep-sleep wake re-arms the same start-up delay
    sleepDeep <= 1'b1;
    @(posedge ref_clk);
    sleepDeep <= 1'b0;
    time_conv(a);
    compare(a >= b - 1 && a <= b + 1, 1'b1);
    wr(`ACS_OFF_DELAY, 8'h00);
    time_conv(a);
    wr(`ACS_OFF_SAMPLE_PHASE_EXTENSION, 8'h03);
    time_conv(b);
    compare(b - a >= 5 && b - a <= 7, 1'b1);
    wr(`ACS_OFF_SAMPLE_PHASE_EXTENSION, 8'h00);
    wr(`ACS_OFF_ACCUM, 8'h01);
    time_conv(a);
    wr(`ACS_OFF_DELAY, 8'h05);
    time_conv(b);
    compare(b - a >= 9 && b - a <= 11, 1'b1);
    wr(`ACS_OFF_DELAY, 8'h1F);
    time_conv(a);
    rd(`ACS_OFF_DELAY);
    compare(rdVal, 8'h11);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    reset = 1'b1;
    {regWrite, regRead, sleepStandby, sleepDeep} = 4'h0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    analogLevel = 10'h000;
    fail_count = 0;
    check_count = 0;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_convert();
    t_modes();
    t_timing();
    wrap_up();
  end
endmodule
`default_nettype wire
